// file: logic/pieb_pkg.sv
/*
 * constants for the first peripheral interrupt enable bank:
 * register offsets, field positions, reset values and bus answers.
 * assumes a 32-bit AXI4-Lite register bus, one aligned word per register.
 */
package pieb_pkg;

    localparam int unsigned ADDR_W = 8;

    // register byte addresses
    localparam logic [ADDR_W-1:0] OFF_ENABLE_ONE = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_PERIPH_GATE = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_RESET_CTRL = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_RAW_FLAGS = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_GATED_REQ = 8'h10;

    // enable bit positions
    localparam int unsigned BIT_WIDE_TIMER_OVF = 0;
    localparam int unsigned BIT_PERIOD_MATCH = 1;
    localparam int unsigned BIT_FIRST_CAPTURE = 2;
    localparam int unsigned BIT_SYNC_SERIAL = 3;
    localparam int unsigned BIT_FIRST_SERIAL_TX = 4;
    localparam int unsigned BIT_FIRST_SERIAL_RX = 5;
    localparam int unsigned BIT_CONVERTER = 6;
    localparam int unsigned BIT_PARALLEL_PORT = 7;

    // control bit positions
    localparam int unsigned BIT_GLOBAL_GATE = 0;
    localparam int unsigned BIT_PRIORITY_ON = 7;

    // reset values
    localparam logic [7:0] RST_ENABLE_ONE = 8'h00;
    localparam logic RST_GLOBAL_GATE = 1'b0;
    localparam logic RST_PRIORITY_ON = 1'b0;

    // AXI answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// file: logic/pieb_axil_slave.sv
/*
 * AXI4-Lite slave front end: takes write address and data in either
 * order, issues a one-cycle write strobe, answers reads from a
 * combinational read port of the register file.
 * assumes the register file decodes the address and flags unmapped ones.
 */
`timescale 1ns/1ps
module pieb_axil_slave
(
    // clock and reset
    input  wire logic                      clk_sys,
    input  wire logic                      reset_n,
    // AXI4-Lite
    input  wire logic [pieb_pkg::ADDR_W-1:0] s_awaddr,
    input  wire logic                      s_awvalid,
    output logic                           s_awready,
    input  wire logic [31:0]               s_wdata,
    input  wire logic [3:0]                s_wstrb,
    input  wire logic                      s_wvalid,
    output logic                           s_wready,
    output logic [1:0]                     s_bresp,
    output logic                           s_bvalid,
    input  wire logic                      s_bready,
    input  wire logic [pieb_pkg::ADDR_W-1:0] s_araddr,
    input  wire logic                      s_arvalid,
    output logic                           s_arready,
    output logic [31:0]                    s_rdata,
    output logic [1:0]                     s_rresp,
    output logic                           s_rvalid,
    input  wire logic                      s_rready,
    // register file side
    output logic                           wr_en,
    output logic [pieb_pkg::ADDR_W-1:0]    wr_addr,
    output logic [31:0]                    wr_data,
    output logic [3:0]                     wr_strb,
    input  wire logic                      wr_err,
    output logic [pieb_pkg::ADDR_W-1:0]    rd_addr,
    input  wire logic [31:0]               rd_data,
    input  wire logic                      rd_err
);

    logic aw_hold_q;
    logic w_hold_q;

    assign wr_en   = aw_hold_q && w_hold_q && !s_bvalid;
    assign rd_addr = s_araddr;

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            s_awready <= 1'b0;
            s_wready  <= 1'b0;
            s_bvalid  <= 1'b0;
            s_bresp   <= pieb_pkg::RESP_OKAY;
            wr_addr   <= '0;
            wr_data   <= 32'h0000_0000;
            wr_strb   <= 4'h0;
        end
        else
        begin
            if (!aw_hold_q && !s_bvalid)
                s_awready <= 1'b1;
            if (!w_hold_q && !s_bvalid)
                s_wready <= 1'b1;
            if (s_awvalid && s_awready)
            begin
                aw_hold_q <= 1'b1;
                wr_addr   <= s_awaddr;
                s_awready <= 1'b0;
            end
            if (s_wvalid && s_wready)
            begin
                w_hold_q <= 1'b1;
                wr_data  <= s_wdata;
                wr_strb  <= s_wstrb;
                s_wready <= 1'b0;
            end
            if (wr_en)
            begin
                aw_hold_q <= 1'b0;
                w_hold_q  <= 1'b0;
                s_bvalid  <= 1'b1;
                s_bresp   <= wr_err ? pieb_pkg::RESP_SLVERR : pieb_pkg::RESP_OKAY;
            end
            if (s_bvalid && s_bready)
                s_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            s_arready <= 1'b0;
            s_rvalid  <= 1'b0;
            s_rdata   <= 32'h0000_0000;
            s_rresp   <= pieb_pkg::RESP_OKAY;
        end
        else
        begin
            if (!s_rvalid && !s_arready)
                s_arready <= 1'b1;
            if (s_arvalid && s_arready)
            begin
                s_arready <= 1'b0;
                s_rvalid  <= 1'b1;
                s_rdata   <= rd_data;
                s_rresp   <= rd_err ? pieb_pkg::RESP_SLVERR : pieb_pkg::RESP_OKAY;
            end
            if (s_rvalid && s_rready)
                s_rvalid <= 1'b0;
        end
    end

endmodule

// file: logic/pieb_bank.sv
/*
 * first peripheral interrupt enable bank: eight enable bits, the global
 * peripheral gate and the priority scheme switch, per-source gating of
 * request flags and the combined request toward the CPU.
 * assumes request flags come from logic on clk_sys; the mode pin is async.
 */
`timescale 1ns/1ps
module pieb_bank
#(
    parameter bit HAS_EXT_MEM = 1'b1
)
(
    // clock and reset
    input  wire logic                        clk_sys,
    input  wire logic                        reset_n,
    // AXI4-Lite
    input  wire logic [pieb_pkg::ADDR_W-1:0] s_awaddr,
    input  wire logic                        s_awvalid,
    output logic                             s_awready,
    input  wire logic [31:0]                 s_wdata,
    input  wire logic [3:0]                  s_wstrb,
    input  wire logic                        s_wvalid,
    output logic                             s_wready,
    output logic [1:0]                       s_bresp,
    output logic                             s_bvalid,
    input  wire logic                        s_bready,
    input  wire logic [pieb_pkg::ADDR_W-1:0] s_araddr,
    input  wire logic                        s_arvalid,
    output logic                             s_arready,
    output logic [31:0]                      s_rdata,
    output logic [1:0]                       s_rresp,
    output logic                             s_rvalid,
    input  wire logic                        s_rready,
    // peripheral flags and mode pin
    input  wire logic [7:0]                  periph_flag,
    input  wire logic                        mcu_mode_pin,
    // toward the CPU interrupt logic
    output logic [7:0]                       periph_req_q,
    output logic                             periph_irq_q
);

    logic                        wr_en;
    logic [pieb_pkg::ADDR_W-1:0] wr_addr;
    logic [31:0]                 wr_data;
    logic [3:0]                  wr_strb;
    logic [pieb_pkg::ADDR_W-1:0] rd_addr;
    logic [31:0]                 rd_data;
    logic                        rd_err;
    logic                        wr_err;

    logic [7:0] peripheral_irq_enable_one_q;
    logic       global_peripheral_irq_gate_q;
    logic       priority_scheme_on_q;
    logic       mode_meta_q;
    logic       mode_sync_q;

    ////////////////////////////////////////////////////////////////////////////
    // bus front end

    pieb_axil_slave u_slave
    (
        .clk_sys   (clk_sys),
        .reset_n   (reset_n),
        .s_awaddr  (s_awaddr),
        .s_awvalid (s_awvalid),
        .s_awready (s_awready),
        .s_wdata   (s_wdata),
        .s_wstrb   (s_wstrb),
        .s_wvalid  (s_wvalid),
        .s_wready  (s_wready),
        .s_bresp   (s_bresp),
        .s_bvalid  (s_bvalid),
        .s_bready  (s_bready),
        .s_araddr  (s_araddr),
        .s_arvalid (s_arvalid),
        .s_arready (s_arready),
        .s_rdata   (s_rdata),
        .s_rresp   (s_rresp),
        .s_rvalid  (s_rvalid),
        .s_rready  (s_rready),
        .wr_en     (wr_en),
        .wr_addr   (wr_addr),
        .wr_data   (wr_data),
        .wr_strb   (wr_strb),
        .wr_err    (wr_err),
        .rd_addr   (rd_addr),
        .rd_data   (rd_data),
        .rd_err    (rd_err)
    );

    ////////////////////////////////////////////////////////////////////////////
    // address decode

    wire wr_hit_enable = (wr_addr == pieb_pkg::OFF_ENABLE_ONE);
    wire wr_hit_gate   = (wr_addr == pieb_pkg::OFF_PERIPH_GATE);
    wire wr_hit_rctrl  = (wr_addr == pieb_pkg::OFF_RESET_CTRL);
    wire wr_hit_ro     = (wr_addr == pieb_pkg::OFF_RAW_FLAGS) || (wr_addr == pieb_pkg::OFF_GATED_REQ);
    wire wr_lane0      = wr_en && wr_strb[0];

    // read-only registers ignore writes but answer OKAY
    assign wr_err = !(wr_hit_enable || wr_hit_gate || wr_hit_rctrl || wr_hit_ro);

    wire rd_hit_enable = (rd_addr == pieb_pkg::OFF_ENABLE_ONE);
    wire rd_hit_gate   = (rd_addr == pieb_pkg::OFF_PERIPH_GATE);
    wire rd_hit_rctrl  = (rd_addr == pieb_pkg::OFF_RESET_CTRL);
    wire rd_hit_raw    = (rd_addr == pieb_pkg::OFF_RAW_FLAGS);
    wire rd_hit_req    = (rd_addr == pieb_pkg::OFF_GATED_REQ);

    wire [7:0] gate_byte  = 8'(global_peripheral_irq_gate_q) << pieb_pkg::BIT_GLOBAL_GATE;
    wire [7:0] rctrl_byte = 8'(priority_scheme_on_q) << pieb_pkg::BIT_PRIORITY_ON;
    wire [7:0] rd_byte    = rd_hit_enable ? peripheral_irq_enable_one_q :
                            rd_hit_gate   ? gate_byte :
                            rd_hit_rctrl  ? rctrl_byte :
                            rd_hit_raw    ? periph_flag :
                            rd_hit_req    ? periph_req_q : 8'h00;

    assign rd_data = {24'h00_0000, rd_byte};
    assign rd_err  = !(rd_hit_enable || rd_hit_gate || rd_hit_rctrl || rd_hit_raw || rd_hit_req);

    ////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            peripheral_irq_enable_one_q  <= pieb_pkg::RST_ENABLE_ONE;
            global_peripheral_irq_gate_q <= pieb_pkg::RST_GLOBAL_GATE;
            priority_scheme_on_q         <= pieb_pkg::RST_PRIORITY_ON;
        end
        else if (wr_lane0)
        begin
            if (wr_hit_enable)
                peripheral_irq_enable_one_q <= wr_data[7:0];
            if (wr_hit_gate)
                global_peripheral_irq_gate_q <= wr_data[pieb_pkg::BIT_GLOBAL_GATE];
            if (wr_hit_rctrl)
                priority_scheme_on_q <= wr_data[pieb_pkg::BIT_PRIORITY_ON];
        end
    end

    // mode pin synchroniser
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            mode_meta_q <= 1'b0;
            mode_sync_q <= 1'b0;
        end
        else
        begin
            mode_meta_q <= mcu_mode_pin;
            mode_sync_q <= mode_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // per-source gating

    // parallel port enable only counts in microcontroller mode on external-memory parts
    wire       psp_allowed = !HAS_EXT_MEM || mode_sync_q;
    wire [7:0] src_mask    = {psp_allowed, 7'h7F};
    wire [7:0] req_d;

    genvar g;
    generate
        for (g = 0; g < 8; g++)
        begin : g_gate
            // one enable per source
            assign req_d[g] = periph_flag[g] && peripheral_irq_enable_one_q[g] && src_mask[g];
        end
    endgenerate

    wire irq_d = (|req_d) && (priority_scheme_on_q || global_peripheral_irq_gate_q);

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            periph_req_q <= 8'h00;
            periph_irq_q <= 1'b0;
        end
        else
        begin
            periph_req_q <= req_d;
            periph_irq_q <= irq_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    sequence s_enable_write;
        wr_lane0 && wr_hit_enable;
    endsequence

    property p_enable_write;
        s_enable_write |=> (peripheral_irq_enable_one_q == $past(wr_data[7:0]));
    endproperty
    a_enable_write: assert property (p_enable_write) else $error("enable write not stored");

    property p_gate_blocks;
        (!priority_scheme_on_q && !global_peripheral_irq_gate_q) |=> !periph_irq_q;
    endproperty
    a_gate_blocks: assert property (p_gate_blocks) else $error("request passed with gate off");

    property p_irq_combine;
        ((|req_d) && (priority_scheme_on_q || global_peripheral_irq_gate_q)) |=> periph_irq_q;
    endproperty
    a_irq_combine: assert property (p_irq_combine) else $error("combined request missing");

    property p_and_form;
        1'b1 |=> (periph_req_q == ($past(periph_flag) & $past(peripheral_irq_enable_one_q) & $past(src_mask)));
    endproperty
    a_and_form: assert property (p_and_form) else $error("request not flag and enable");

    property p_rx_block;
        !peripheral_irq_enable_one_q[pieb_pkg::BIT_FIRST_SERIAL_RX] |=> !periph_req_q[pieb_pkg::BIT_FIRST_SERIAL_RX];
    endproperty
    a_rx_block: assert property (p_rx_block) else $error("serial receive not blocked");

    property p_tx_pass;
        (peripheral_irq_enable_one_q[pieb_pkg::BIT_FIRST_SERIAL_TX] && periph_flag[pieb_pkg::BIT_FIRST_SERIAL_TX])
            |=> periph_req_q[pieb_pkg::BIT_FIRST_SERIAL_TX];
    endproperty
    a_tx_pass: assert property (p_tx_pass) else $error("serial transmit not passed");

    property p_ssp_block;
        !peripheral_irq_enable_one_q[pieb_pkg::BIT_SYNC_SERIAL] |=> !periph_req_q[pieb_pkg::BIT_SYNC_SERIAL];
    endproperty
    a_ssp_block: assert property (p_ssp_block) else $error("sync serial not blocked");

    property p_ccp_pass;
        (peripheral_irq_enable_one_q[pieb_pkg::BIT_FIRST_CAPTURE] && periph_flag[pieb_pkg::BIT_FIRST_CAPTURE])
            |=> periph_req_q[pieb_pkg::BIT_FIRST_CAPTURE];
    endproperty
    a_ccp_pass: assert property (p_ccp_pass) else $error("capture request not passed");

    property p_match_block;
        !peripheral_irq_enable_one_q[pieb_pkg::BIT_PERIOD_MATCH] |=> !periph_req_q[pieb_pkg::BIT_PERIOD_MATCH];
    endproperty
    a_match_block: assert property (p_match_block) else $error("period match not blocked");

    property p_ovf_pass;
        (peripheral_irq_enable_one_q[pieb_pkg::BIT_WIDE_TIMER_OVF] && periph_flag[pieb_pkg::BIT_WIDE_TIMER_OVF])
            |=> periph_req_q[pieb_pkg::BIT_WIDE_TIMER_OVF];
    endproperty
    a_ovf_pass: assert property (p_ovf_pass) else $error("timer overflow not passed");

endmodule

// file: bench/pieb_flag_model.sv
/*
 * partner model: peripheral flag sources and the CPU side of the bank.
 * assumes the bench commands flag levels on clk_sys.
 */
`timescale 1ns/1ps
module pieb_flag_model
(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    // commanded flag levels
    input  wire logic [7:0]  flag_cmd,
    // flags toward the bank
    output logic [7:0]       periph_flag,
    // CPU side
    input  wire logic        periph_irq_q,
    output logic [15:0]      irq_cycles
);
    // flags are levels held until their source drops them
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            periph_flag <= 8'h00;
            irq_cycles  <= 16'h0000;
        end
        else
        begin
            periph_flag <= flag_cmd;
            if (periph_irq_q)
                irq_cycles <= irq_cycles + 16'h0001;
        end
    end
endmodule

// file: bench/peripheral_irq_enable_bank_tb.sv
/*
 * self-checking bench of the first peripheral interrupt enable bank.
 * assumes the bank answers on AXI4-Lite and gates flags one cycle late.
 */
`timescale 1ns/1ps
module peripheral_irq_enable_bank_tb;
    logic        clk_sys;
    logic        reset_n;
    logic [7:0]  s_awaddr;
    logic        s_awvalid;
    logic        s_awready;
    logic [31:0] s_wdata;
    logic [3:0]  s_wstrb;
    logic        s_wvalid;
    logic        s_wready;
    logic [1:0]  s_bresp;
    logic        s_bvalid;
    logic        s_bready;
    logic [7:0]  s_araddr;
    logic        s_arvalid;
    logic        s_arready;
    logic [31:0] s_rdata;
    logic [1:0]  s_rresp;
    logic        s_rvalid;
    logic        s_rready;
    logic [7:0]  flag_cmd;
    logic [7:0]  periph_flag;
    logic        mcu_mode_pin;
    logic [7:0]  periph_req_q;
    logic        periph_irq_q;
    logic [15:0] irq_cycles;
    logic [15:0] irq_mark;
    logic [7:0]  lfsr;
    logic [7:0]  en;
    logic [7:0]  fl;
    logic [7:0]  ctl;
    logic [7:0]  er;
    int          err_total;
    int          n_tests;
    int          cyc;

    pieb_bank u_pieb_bank (.clk_sys(clk_sys), .reset_n(reset_n), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
        .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
        .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
        .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
        .periph_flag(periph_flag), .mcu_mode_pin(mcu_mode_pin), .periph_req_q(periph_req_q),
        .periph_irq_q(periph_irq_q));

    pieb_flag_model u_pieb_flag_model (.clk_sys(clk_sys), .reset_n(reset_n), .flag_cmd(flag_cmd),
        .periph_flag(periph_flag), .periph_irq_q(periph_irq_q), .irq_cycles(irq_cycles));

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_total++;
            test_done();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    // expected gated requests: mode low blocks the parallel port bit
    function automatic logic [7:0] exp_req(input logic [7:0] e, input logic [7:0] f, input logic m);
        logic [7:0] r;
        r = e & f;
        r[pieb_pkg::BIT_PARALLEL_PORT] = r[pieb_pkg::BIT_PARALLEL_PORT] & m;
        return r;
    endfunction

    function automatic logic exp_irq(input logic [7:0] r, input logic gate, input logic prio);
        return prio ? (|r) : (gate & (|r));
    endfunction

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st, input logic [1:0] rs);
        @(posedge clk_sys);
        s_awaddr  <= a;
        s_awvalid <= 1'b1;
        s_wdata   <= d;
        s_wstrb   <= st;
        s_wvalid  <= 1'b1;
        s_bready  <= 1'b1;
        forever
        begin
            @(posedge clk_sys);
            if (s_awready === 1'b1)
                s_awvalid <= 1'b0;
            if (s_wready === 1'b1)
                s_wvalid <= 1'b0;
            if (s_bvalid === 1'b1)
            begin
                chk("bresp", {30'h0, rs}, {30'h0, s_bresp});
                s_bready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic reg_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] rs);
        @(posedge clk_sys);
        s_araddr  <= a;
        s_arvalid <= 1'b1;
        s_rready  <= 1'b1;
        forever
        begin
            @(posedge clk_sys);
            if (s_arready === 1'b1)
                s_arvalid <= 1'b0;
            if (s_rvalid === 1'b1)
            begin
                chk("rresp", {30'h0, rs}, {30'h0, s_rresp});
                chk("rdata", ed, s_rdata);
                s_rready <= 1'b0;
                break;
            end
        end
    endtask

    // flags cross the model, the mode pin two flops, then the request register
    task automatic settle();
        repeat (5) @(posedge clk_sys);
        #1;
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {s_awaddr, s_awvalid, s_wdata, s_wstrb, s_wvalid, s_bready} = '0;
        {s_araddr, s_arvalid, s_rready} = '0;
        {flag_cmd, mcu_mode_pin, err_total, n_tests, cyc} = '0;
        reset_n = 1'b0;
        lfsr    = 8'h44;
        repeat (5) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        reg_rd(pieb_pkg::OFF_ENABLE_ONE, 32'h0, pieb_pkg::RESP_OKAY);
        reg_rd(pieb_pkg::OFF_PERIPH_GATE, 32'h0, pieb_pkg::RESP_OKAY);
        reg_rd(pieb_pkg::OFF_RESET_CTRL, 32'h0, pieb_pkg::RESP_OKAY);
        reg_wr(pieb_pkg::OFF_RESET_CTRL, 32'hFF, 4'h1, pieb_pkg::RESP_OKAY);
        reg_rd(pieb_pkg::OFF_RESET_CTRL, 32'h80, pieb_pkg::RESP_OKAY);
        reg_wr(pieb_pkg::OFF_RESET_CTRL, 32'h0, 4'h1, pieb_pkg::RESP_OKAY);
        reg_wr(8'h14, 32'hFF, 4'h1, pieb_pkg::RESP_SLVERR);
        reg_rd(8'h14, 32'h0, pieb_pkg::RESP_SLVERR);
        reg_wr(pieb_pkg::OFF_ENABLE_ONE, 32'hFF, 4'h0, pieb_pkg::RESP_OKAY);
        reg_rd(pieb_pkg::OFF_ENABLE_ONE, 32'h0, pieb_pkg::RESP_OKAY);
        reg_wr(pieb_pkg::OFF_GATED_REQ, 32'hFF, 4'h1, pieb_pkg::RESP_OKAY);
        reg_rd(pieb_pkg::OFF_GATED_REQ, 32'h0, pieb_pkg::RESP_OKAY);
        // one source at a time, every flag raised
        flag_cmd     <= 8'hFF;
        mcu_mode_pin <= 1'b1;
        reg_wr(pieb_pkg::OFF_PERIPH_GATE, 32'h1, 4'h1, pieb_pkg::RESP_OKAY);
        for (int i = 0; i < 8; i++)
        begin
            er = 8'h01 << i;
            reg_wr(pieb_pkg::OFF_ENABLE_ONE, {24'h0, er}, 4'h1, pieb_pkg::RESP_OKAY);
            settle();
            chk("periph_req_q", {24'h0, er}, {24'h0, periph_req_q});
            chk("req_bit", 32'h1, {31'h0, periph_req_q[i]});
            chk("periph_irq_q", 32'h1, {31'h0, periph_irq_q});
            reg_rd(pieb_pkg::OFF_ENABLE_ONE, {24'h0, er}, pieb_pkg::RESP_OKAY);
        end
        mcu_mode_pin <= 1'b0;
        settle();
        chk("periph_req_q", 32'h0, {24'h0, periph_req_q});
        reg_wr(pieb_pkg::OFF_ENABLE_ONE, 32'hFF, 4'h1, pieb_pkg::RESP_OKAY);
        reg_wr(pieb_pkg::OFF_PERIPH_GATE, 32'h0, 4'h1, pieb_pkg::RESP_OKAY);
        settle();
        irq_mark = irq_cycles;
        settle();
        chk("periph_irq_q", 32'h0, {31'h0, periph_irq_q});
        chk("irq_cycles", {16'h0, irq_mark}, {16'h0, irq_cycles});
        // random enables, flags, gate, priority scheme and mode
        for (int k = 0; k < 48; k++)
        begin
            lfsr = lfsr_next(lfsr);
            en   = lfsr;
            lfsr = lfsr_next(lfsr);
            fl   = lfsr;
            lfsr = lfsr_next(lfsr);
            ctl  = lfsr;
            flag_cmd     <= fl;
            mcu_mode_pin <= ctl[1];
            reg_wr(pieb_pkg::OFF_ENABLE_ONE, {24'h0, en}, 4'h1, pieb_pkg::RESP_OKAY);
            reg_wr(pieb_pkg::OFF_PERIPH_GATE, {31'h0, ctl[0]}, 4'h1, pieb_pkg::RESP_OKAY);
            reg_wr(pieb_pkg::OFF_RESET_CTRL, {24'h0, ctl[7], 7'h0}, 4'h1, pieb_pkg::RESP_OKAY);
            settle();
            er = exp_req(en, fl, ctl[1]);
            chk("periph_req_q", {24'h0, er}, {24'h0, periph_req_q});
            chk("periph_irq_q", {31'h0, exp_irq(er, ctl[0], ctl[7])}, {31'h0, periph_irq_q});
            reg_rd(pieb_pkg::OFF_GATED_REQ, {24'h0, er}, pieb_pkg::RESP_OKAY);
            reg_rd(pieb_pkg::OFF_RAW_FLAGS, {24'h0, fl}, pieb_pkg::RESP_OKAY);
        end
        test_done();
    end
endmodule
